// ==== logic/rfr_defines.vh ====
// Register offsets, field positions, reset values and widths of the fault record register bank
`ifndef RFR_DEFINES_VH
`define RFR_DEFINES_VH

// Register byte offsets on the bus
`define RFR_LOG_BASE_LO 8'h58
`define RFR_LOG_BASE_HI 8'h5C
`define RFR_SLOT_W0 8'h80
`define RFR_SLOT_W1 8'h84
`define RFR_SLOT_W2 8'h88
`define RFR_SLOT_W3 8'h8C
`define RFR_ACT_BASE_LO 8'h90
`define RFR_ACT_BASE_HI 8'h94
`define RFR_STATUS 8'h98
`define RFR_CAP 8'h9C

// Fault record slot field positions (bit index within the 128-bit slot)
`define RFR_VALID_BIT 127
`define RFR_KIND_BIT 126
`define RFR_ATYPE_HI 125
`define RFR_ATYPE_LO 124
`define RFR_REASON_HI 103
`define RFR_REASON_LO 96
`define RFR_REQID_HI 79
`define RFR_REQID_LO 64
`define RFR_INFO_HI 63
`define RFR_INFO_LO 12
`define RFR_IRINDEX_LO 48

// Log base register fields
`define RFR_SIZE_HI 11
`define RFR_SIZE_LO 9
`define RFR_BASE_LO 12

// Host and guest address widths
`define RFR_HOST_AW 48
`define RFR_GUEST_AW 48

// Status and capability bit positions
`define RFR_ST_PENDING 0
`define RFR_ST_BUSY 1
`define RFR_CAP_DEVTLB 0
`define RFR_CAP_ADVLOG 1

// Reset values
`define RFR_LOG_BASE_RST 64'h0000_0000_0000_0000
`define RFR_SLOT_RST 128'h0000_0000_0000_0000_0000_0000_0000_0000

// Fault reason codes at or above this value are interrupt-remapping faults
`define RFR_IR_REASON_MIN 8'h20

`endif

// ==== logic/rfr_wb_slave.v ====
// Classic Wishbone slave front end producing one-cycle register strobes
`timescale 1ns/1ns
module rfr_wb_slave (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Wishbone
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  output wire wbAck,
  // Register strobes
  output wire regWrite,
  output wire regRead
);
  reg ack_r;

  // Ack one cycle after request, then drop for one cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wbCyc & wbStb & ~ack_r;
    end
  end

  assign wbAck = ack_r;
  assign regWrite = wbCyc & wbStb & wbWe & ~ack_r;
  assign regRead = wbCyc & wbStb & ~wbWe & ~ack_r;
endmodule

// ==== logic/rfr_slot_writer.v ====
// Sequencer that writes a captured fault into the record slot word by word
`timescale 1ns/1ns
`include "rfr_defines.vh"
module rfr_slot_writer (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Capture request
  input wire start,
  // Sequencer state
  output wire busy,
  output wire [1:0] wordSel,
  output wire wordWe,
  output wire setValid
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WORDS = 2'd1;
  localparam ST_FLAG = 2'd2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] word_r;
  reg [1:0] word_nxt;

  always @* begin
    state_nxt = state_r;
    word_nxt = word_r;
    case (state_r)
      ST_IDLE: begin
        word_nxt = 2'd0;
        if (start) begin
          state_nxt = ST_WORDS;
        end
      end
      ST_WORDS: begin
        word_nxt = word_r + 2'd1;
        if (word_r == 2'd3) begin
          state_nxt = ST_FLAG;
        end
      end
      ST_FLAG: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      word_r <= 2'd0;
    end else begin
      state_r <= state_nxt;
      word_r <= word_nxt;
    end
  end

  assign busy = (state_r != ST_IDLE);
  assign wordSel = word_r;
  assign wordWe = (state_r == ST_WORDS);
  assign setValid = (state_r == ST_FLAG);
endmodule

// ==== logic/rfr_fault_regs.v ====
// Fault record slot and advanced fault log base registers behind classic Wishbone
// Operation
// RULE1 - Copy request address type into slot
// RULE2 - No device cache: address type reads zero
// RULE3 - Address type meaningful only for valid DMA faults
// RULE4 - Store eight-bit fault reason code
// RULE5 - Store sixteen-bit requester identifier
// RULE6 - DMA faults store page address in info
// RULE7 - Info bits above guest width read zero
// RULE8 - Interrupt faults: index high, middle bits cleared
// RULE9 - Slot may update as separate words
// RULE10 - Software checks pending flag or valid first
// RULE11 - No advanced logging: log base reads zero
// RULE12 - Log base holds 4KB-aligned region address
// RULE13 - Base bits above host width unimplemented
// RULE14 - Log fields latch only on set-pointer command
// RULE15 - Log size is two-power times 4KB
// RULE16 - Log fields read back last written value
// RULE17 - Valid flag set last, write-one clears
// RULE18 - Request kind: zero write, one read
// RULE19 - Slot contents sticky except power-good reset
// RULE20 - Reserved bits read zero, ignore writes
`timescale 1ns/1ns
`include "rfr_defines.vh"
module rfr_fault_regs (
  // Clock and resets
  input wire clk,
  input wire rst,
  input wire powerGoodRst,
  // Wishbone slave
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatW,
  output reg [31:0] wbDatR,
  output wire wbAck,
  // Capability straps
  input wire deviceTlbSupport,
  input wire advancedLogCapability,
  // Fault capture
  input wire faultValid,
  input wire faultIsWrite,
  input wire [1:0] faultAddressType,
  input wire [7:0] faultReason,
  input wire [15:0] faultRequesterId,
  input wire [51:0] faultPageAddr,
  input wire [15:0] faultIrIndex,
  output wire faultReady,
  // Log pointer command and latched log region
  input wire setLogPointerCmd,
  output reg [63:0] logRegionBase,
  output reg [2:0] logRegionSizeExp,
  output reg [31:0] logRegionPages,
  // Primary pending flag
  output wire primaryPendingFlag
);
  // ******************************************************************
  // Strap capture and bus front end
  // ******************************************************************
  reg tlbCap_r;
  reg advCap_r;
  reg capDone_r;
  wire regWrite;
  wire regRead;

  // Straps are sampled once after reset release
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tlbCap_r <= 1'b0;
      advCap_r <= 1'b0;
      capDone_r <= 1'b0;
    end else if (!capDone_r) begin
      tlbCap_r <= deviceTlbSupport;
      advCap_r <= advancedLogCapability;
      capDone_r <= 1'b1;
    end
  end

  rfr_wb_slave uBus (
    .clk(clk),
    .rst(rst),
    .wbCyc(wbCyc),
    .wbStb(wbStb),
    .wbWe(wbWe),
    .wbAck(wbAck),
    .regWrite(regWrite),
    .regRead(regRead)
  );

  // ******************************************************************
  // Byte-lane write merge
  // ******************************************************************
  function [31:0] laneMerge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0] sel;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        laneMerge[i*8 +: 8] = sel[i] ? newVal[i*8 +: 8] : oldVal[i*8 +: 8];
      end
    end
  endfunction

  // ******************************************************************
  // Advanced fault log base register
  // ******************************************************************
  reg [63:0] logBase_r;
  wire [63:0] logBaseMask;

  // Implemented bits: size 11:9 and base 47:12
  assign logBaseMask = {{(64-`RFR_HOST_AW){1'b0}}, {(`RFR_HOST_AW-`RFR_BASE_LO){1'b1}},
    3'b111, 9'h000}; // RULE13 RULE20

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      logBase_r <= `RFR_LOG_BASE_RST;
    end else if (regWrite && advCap_r) begin
      if (wbAdr == `RFR_LOG_BASE_LO) begin
        logBase_r[31:0] <= laneMerge(logBase_r[31:0], wbDatW, wbSel) & logBaseMask[31:0]; // RULE16
      end else if (wbAdr == `RFR_LOG_BASE_HI) begin
        logBase_r[63:32] <= laneMerge(logBase_r[63:32], wbDatW, wbSel) & logBaseMask[63:32]; // RULE16
      end
    end
  end

  // Active region changes only on the set-log-pointer command
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      logRegionBase <= 64'h0000_0000_0000_0000;
      logRegionSizeExp <= 3'h0;
      logRegionPages <= 32'h0000_0001;
    end else if (setLogPointerCmd && advCap_r) begin // RULE14
      logRegionBase <= {logBase_r[63:`RFR_BASE_LO], 12'h000}; // RULE12
      logRegionSizeExp <= logBase_r[`RFR_SIZE_HI:`RFR_SIZE_LO];
      logRegionPages <= 32'h0000_0001 << logBase_r[`RFR_SIZE_HI:`RFR_SIZE_LO]; // RULE15
    end
  end

  // ******************************************************************
  // Fault record slot
  // ******************************************************************
  reg [127:0] slot_r;
  reg [127:0] stage_r;
  reg [127:0] stageNxt;
  wire seqBusy;
  wire [1:0] wordSel;
  wire wordWe;
  wire setValid;
  wire isIrFault;
  wire clearValid;
  wire [63:0] dmaInfo;
  wire [63:0] guestMask;

  assign isIrFault = (faultReason >= `RFR_IR_REASON_MIN);
  assign guestMask = {{(64-`RFR_GUEST_AW){1'b0}}, {`RFR_GUEST_AW{1'b1}}};
  assign dmaInfo = {faultPageAddr, 12'h000} & guestMask; // RULE6 RULE7

  // Collapse new faults while a record is held or being written
  assign faultReady = ~slot_r[`RFR_VALID_BIT] & ~seqBusy;

  always @* begin
    stageNxt = 128'h0;
    stageNxt[`RFR_KIND_BIT] = ~faultIsWrite; // RULE18
    if (tlbCap_r && !isIrFault) begin
      stageNxt[`RFR_ATYPE_HI:`RFR_ATYPE_LO] = faultAddressType; // RULE1 RULE2 RULE3
    end
    stageNxt[`RFR_REASON_HI:`RFR_REASON_LO] = faultReason; // RULE4
    stageNxt[`RFR_REQID_HI:`RFR_REQID_LO] = faultRequesterId; // RULE5
    if (isIrFault) begin
      stageNxt[`RFR_INFO_HI:`RFR_IRINDEX_LO] = faultIrIndex; // RULE8
    end else begin
      stageNxt[`RFR_INFO_HI:`RFR_INFO_LO] = dmaInfo[63:12];
    end
  end

  rfr_slot_writer uSeq (
    .clk(clk),
    .rst(rst),
    .start(faultValid & faultReady),
    .busy(seqBusy),
    .wordSel(wordSel),
    .wordWe(wordWe),
    .setValid(setValid)
  );

  assign clearValid = regWrite && (wbAdr == `RFR_SLOT_W3) && wbSel[3] && wbDatW[31];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_r <= `RFR_SLOT_RST;
    end else if (faultValid && faultReady) begin
      stage_r <= stageNxt;
    end
  end

  // Sticky: only power-good reset clears the slot
  always @(posedge clk or posedge powerGoodRst) begin
    if (powerGoodRst) begin
      slot_r <= `RFR_SLOT_RST; // RULE19
    end else begin
      if (wordWe) begin
        slot_r[wordSel*32 +: 31] <= stage_r[wordSel*32 +: 31]; // RULE9
        if (wordSel != 2'd3) begin
          slot_r[wordSel*32 + 31] <= stage_r[wordSel*32 + 31];
        end
      end
      if (setValid) begin
        slot_r[`RFR_VALID_BIT] <= 1'b1; // RULE17
      end else if (clearValid) begin
        slot_r[`RFR_VALID_BIT] <= 1'b0; // RULE17
      end
    end
  end

  assign primaryPendingFlag = slot_r[`RFR_VALID_BIT]; // RULE10

  // ******************************************************************
  // Read mux
  // ******************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wbDatR <= 32'h0000_0000;
    end else if (regRead) begin
      case (wbAdr)
        `RFR_LOG_BASE_LO: wbDatR <= advCap_r ? logBase_r[31:0] : 32'h0000_0000; // RULE11
        `RFR_LOG_BASE_HI: wbDatR <= advCap_r ? logBase_r[63:32] : 32'h0000_0000; // RULE11
        `RFR_SLOT_W0: wbDatR <= slot_r[31:0];
        `RFR_SLOT_W1: wbDatR <= slot_r[63:32];
        `RFR_SLOT_W2: wbDatR <= slot_r[95:64];
        `RFR_SLOT_W3: wbDatR <= slot_r[127:96];
        `RFR_ACT_BASE_LO: wbDatR <= logRegionBase[31:0];
        `RFR_ACT_BASE_HI: wbDatR <= logRegionBase[63:32];
        `RFR_STATUS: wbDatR <= {30'h0, seqBusy, slot_r[`RFR_VALID_BIT]};
        `RFR_CAP: wbDatR <= {30'h0, advCap_r, tlbCap_r};
        default: wbDatR <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== testbench/rfr_fault_checker.sv ====
// Concurrent checks on the ports of the fault record register bank
`timescale 1ns/1ns
module rfr_fault_checker (
  // Clock and resets
  input wire clk,
  input wire rst,
  input wire powerGoodRst,
  // Bus
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire wbAck,
  // Straps and fault capture
  input wire advancedLogCapability,
  input wire faultValid,
  input wire faultReady,
  input wire primaryPendingFlag,
  // Log pointer
  input wire setLogPointerCmd,
  input wire [63:0] logRegionBase,
  input wire [2:0] logRegionSizeExp,
  input wire [31:0] logRegionPages
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst || powerGoodRst);
  chk_size_pages:
  assert property (logRegionPages == (32'h0000_0001 << logRegionSizeExp))
    else $error("log page count does not match size");
  chk_log_hold:
  assert property (!setLogPointerCmd |=> $stable(logRegionBase) && $stable(logRegionSizeExp))
    else $error("log region changed without command");
  chk_base_shape:
  assert property (logRegionBase[11:0] == 12'h000 && logRegionBase[63:48] == 16'h0000)
    else $error("log base has bits outside the region field");
  chk_no_adv_log:
  assert property (setLogPointerCmd && !advancedLogCapability |=> $stable(logRegionBase))
    else $error("log command taken without capability");
  chk_ready_drop:
  assert property (faultValid && faultReady |=> !faultReady)
    else $error("fault ready stayed high after capture");
  chk_valid_last:
  assert property (faultValid && faultReady |=> !primaryPendingFlag [*5] ##1 primaryPendingFlag)
    else $error("valid flag not set at the expected cycle");
  chk_slot_busy:
  assert property (primaryPendingFlag |-> !faultReady)
    else $error("fault accepted while slot valid");
  chk_slot_sticky:
  assert property (primaryPendingFlag && !(wbCyc && wbStb && wbWe && !wbAck) |=> primaryPendingFlag)
    else $error("valid flag cleared without a write");
  cover property (setLogPointerCmd && advancedLogCapability);
  cover property (wbAck && wbWe);
  cover property ($rose(primaryPendingFlag));
endmodule

bind rfr_fault_regs rfr_fault_checker u_chk (
  .clk(clk),
  .rst(rst),
  .powerGoodRst(powerGoodRst),
  .wbCyc(wbCyc),
  .wbStb(wbStb),
  .wbWe(wbWe),
  .wbAck(wbAck),
  .advancedLogCapability(advancedLogCapability),
  .faultValid(faultValid),
  .faultReady(faultReady),
  .primaryPendingFlag(primaryPendingFlag),
  .setLogPointerCmd(setLogPointerCmd),
  .logRegionBase(logRegionBase),
  .logRegionSizeExp(logRegionSizeExp),
  .logRegionPages(logRegionPages)
);

// ==== testbench/tb_top.sv ====
// Self-checking bench for the fault record register bank
`timescale 1ns/1ns
`include "rfr_defines.vh"
module tb_top;
  logic clk = 1'h0, rst = 1'h1, powerGoodRst = 1'h1;
  logic wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0000_0000;
  logic deviceTlbSupport = 1'h1, advancedLogCapability = 1'h1;
  logic faultValid = 1'h0, faultIsWrite = 1'h0, setLogPointerCmd = 1'h0;
  logic [1:0] faultAddressType = 2'h0;
  logic [7:0] faultReason = 8'h00;
  logic [15:0] faultRequesterId = 16'h0000, faultIrIndex = 16'h0000;
  logic [51:0] faultPageAddr = 52'h0;
  logic [31:0] wbDatR, logRegionPages;
  logic wbAck, faultReady, primaryPendingFlag;
  logic [63:0] logRegionBase;
  logic [2:0] logRegionSizeExp;
  int failures = 0;
  int checkCount = 0;

  rfr_fault_regs dut (.clk(clk), .rst(rst), .powerGoodRst(powerGoodRst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hF), .wbDatW(wbDatW),
    .wbDatR(wbDatR), .wbAck(wbAck), .deviceTlbSupport(deviceTlbSupport),
    .advancedLogCapability(advancedLogCapability), .faultValid(faultValid),
    .faultIsWrite(faultIsWrite), .faultAddressType(faultAddressType),
    .faultReason(faultReason), .faultRequesterId(faultRequesterId),
    .faultPageAddr(faultPageAddr), .faultIrIndex(faultIrIndex), .faultReady(faultReady),
    .setLogPointerCmd(setLogPointerCmd), .logRegionBase(logRegionBase),
    .logRegionSizeExp(logRegionSizeExp), .logRegionPages(logRegionPages),
    .primaryPendingFlag(primaryPendingFlag));

  // ****************************************
  // Bus, fault and compare tasks
  // ****************************************
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checkCount++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'h3, we, a, d};
    do @(negedge clk); while (wbAck !== 1'h1);
    @(posedge clk);
    q = wbDatR;
    {wbCyc, wbStb} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
    logic [31:0] q;
    bus(1'h0, a, 32'h0000_0000, q);
    chk(nm, {32'h0000_0000, e}, {32'h0000_0000, q & m});
  endtask
  task automatic fault(input logic w, input logic [1:0] at, input logic [7:0] r,
      input logic [15:0] id, input logic [51:0] pg, input logic [15:0] ix);
    @(posedge clk);
    {faultValid, faultIsWrite, faultAddressType, faultReason, faultRequesterId,
      faultPageAddr, faultIrIndex} <= {1'h1, w, at, r, id, pg, ix};
    do @(negedge clk); while (faultReady !== 1'h1);
    @(posedge clk);
    faultValid <= 1'h0;
    repeat (8) @(negedge clk);
  endtask
  task automatic pulse;
    @(posedge clk);
    setLogPointerCmd <= 1'h1;
    @(posedge clk);
    setLogPointerCmd <= 1'h0;
    @(negedge clk);
  endtask
  task automatic applyReset(input logic pg);
    @(posedge clk);
    rst <= 1'h1;
    powerGoodRst <= pg;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    powerGoodRst <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task tally_and_finish;
    $display("Comparisons %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always #20 clk = ~clk;
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish;
  end
  initial begin
    applyReset(1'h1);
    rd("base_lo", `RFR_LOG_BASE_LO, 32'h0000_0000, 32'hFFFF_FFFF);
    rd("slot_w3", `RFR_SLOT_W3, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(`RFR_LOG_BASE_LO, 32'h1234_5FFF);
    wr(`RFR_LOG_BASE_HI, 32'hDEAD_BEEF);
    wr(8'h20, 32'hFFFF_FFFF);
    rd("unmapped", 8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    rd("base_lo", `RFR_LOG_BASE_LO, 32'h1234_5E00, 32'hFFFF_FFFF);
    rd("base_hi", `RFR_LOG_BASE_HI, 32'h0000_BEEF, 32'hFFFF_FFFF);
    chk("active_base", 64'h0, logRegionBase);
    pulse;
    chk("active_base", 64'h0000_BEEF_1234_5000, logRegionBase);
    chk("pages", 64'h80, {32'h0000_0000, logRegionPages});
    fault(1'h0, 2'h2, 8'h05, 16'hA5C3, 52'h1_2345_6789_ABCD, 16'h0000);
    chk("pending", 64'h1, {63'h0, primaryPendingFlag});
    rd("dma_w3", `RFR_SLOT_W3, 32'hE000_0005, 32'hFFFF_FFFF);
    wr(`RFR_SLOT_W2, 32'hFFFF_FFFF);
    rd("dma_w2", `RFR_SLOT_W2, 32'h0000_A5C3, 32'hFFFF_FFFF);
    rd("dma_w1", `RFR_SLOT_W1, 32'h0000_5678, 32'hFFFF_FFFF);
    rd("dma_w0", `RFR_SLOT_W0, 32'h9ABC_D000, 32'hFFFF_FFFF);
    wr(`RFR_SLOT_W3, 32'h0000_0000);
    rd("w3_kept", `RFR_SLOT_W3, 32'h8000_0000, 32'h8000_0000);
    wr(`RFR_SLOT_W3, 32'h8000_0000);
    chk("pending", 64'h0, {63'h0, primaryPendingFlag});
    fault(1'h1, 2'h3, 8'h25, 16'h0F0E, 52'hF_FFFF_FFFF_FFFF, 16'h7E81);
    rd("ir_w3", `RFR_SLOT_W3, 32'h8000_0025, 32'hBFFF_FFFF);
    rd("ir_w1", `RFR_SLOT_W1, 32'h7E81_0000, 32'hFFFF_FFFF);
    rd("ir_w0", `RFR_SLOT_W0, 32'h0000_0000, 32'hFFFF_FFFF);
    deviceTlbSupport <= 1'h0;
    advancedLogCapability <= 1'h0;
    applyReset(1'h0);
    rd("kept_w3", `RFR_SLOT_W3, 32'h8000_0025, 32'hBFFF_FFFF);
    wr(`RFR_LOG_BASE_LO, 32'h1234_5FFF);
    rd("no_log", `RFR_LOG_BASE_LO, 32'h0000_0000, 32'hFFFF_FFFF);
    pulse;
    chk("active_base", 64'h0, logRegionBase);
    wr(`RFR_SLOT_W3, 32'h8000_0000);
    fault(1'h1, 2'h2, 8'h05, 16'h1234, 52'h0_0000_0001_0000, 16'h0000);
    rd("notlb_w3", `RFR_SLOT_W3, 32'h8000_0005, 32'hFFFF_FFFF);
    applyReset(1'h1);
    rd("pg_w3", `RFR_SLOT_W3, 32'h0000_0000, 32'hFFFF_FFFF);
    tally_and_finish;
  end
endmodule
